// ### hw/afe_ctrl_top.sv
// ADC front-end control: input mux, burnout override, chop, gain
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "afe_ctrl_regs.svh"
module afe_ctrl_top
    import afe_ctrl_pkg::*;
#(
    parameter int CONV_CYCLES = 64
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [23:0] i_filter_code,
    input wire logic [7:0] i_scan_mux,
    output logic [31:0] o_rdata,
    output logic [7:0] o_mux_route,
    output logic o_swap_inputs,
    output logic [1:0] o_burnout_sel,
    output logic o_diode_bias_en,
    output logic o_filter_reset,
    output logic [2:0] o_analog_gain,
    output logic o_data_ready
);
    logic [1:0] cs_sel_q;
    logic chop_q;
    logic [2:0] gain_q;
    logic [1:0] mode_q;
    logic [7:0] mux_q;
    logic scan_q;
    logic start;
    afe_state_e state_q;
    logic [15:0] cnt_q;
    afe_code_t pos_q;
    afe_code_t result_q;
    logic signed [24:0] diff;
    logic [7:0] route;
    logic temp_sel;
    logic conv_end;
    afe_gain_if gif ();

    afe_digital_gain u_gain (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .gif(gif)
    );
    assign gif.gain_code = gain_q;

    // Configuration writes
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            cs_sel_q <= 2'h0;
            chop_q <= 1'b0;
            gain_q <= `AFE_GAIN_RESET;
            mode_q <= 2'h0;
            mux_q <= `AFE_MUX_RESET;
            scan_q <= 1'b0;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `AFE_ADDR_CFG0: cs_sel_q <= i_wdata[`AFE_CFG0_CS_LSB +: 2];
                `AFE_ADDR_CFG2:
                begin
                    chop_q <= i_wdata[`AFE_CFG2_CHOP_BIT];
                    gain_q <= i_wdata[`AFE_CFG2_GAIN_LSB +: 3];
                end
                `AFE_ADDR_CFG3: mode_q <= i_wdata[`AFE_CFG3_MODE_LSB +: 2];
                `AFE_ADDR_MUX: mux_q <= i_wdata[7:0];
                `AFE_ADDR_CTRL: scan_q <= i_wdata[`AFE_CTRL_SCAN_BIT];
                default: ;
            endcase
        end
    end

    assign start = i_wr && (i_addr == `AFE_ADDR_CTRL)
        && i_wdata[`AFE_CTRL_START_BIT];
    assign route = scan_q ? i_scan_mux : mux_q;
    assign temp_sel = (route == `AFE_TEMP_MUX_CODE);
    assign conv_end = (cnt_q == 16'(CONV_CYCLES - 1));
    assign diff = (25'(signed'(pos_q)) - 25'(signed'(i_filter_code))) >>> 1;
    assign gif.raw_code = (state_q == AFE_CONV_NEG) ? diff[23:0] : i_filter_code;

    // Conversion sequencer; one phase lasts CONV_CYCLES clocks
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            state_q <= AFE_IDLE;
            cnt_q <= 16'h0000;
            pos_q <= 24'h000000;
            result_q <= 24'h000000;
            o_data_ready <= 1'b0;
            o_filter_reset <= 1'b0;
        end
        else
        begin
            o_data_ready <= 1'b0;
            o_filter_reset <= 1'b0;
            case (state_q)
                AFE_IDLE:
                begin
                    cnt_q <= 16'h0000;
                    if (start || mode_q == `AFE_MODE_CONT)
                        state_q <= AFE_CONV_POS;
                end
                AFE_CONV_POS:
                begin
                    cnt_q <= conv_end ? 16'h0000 : cnt_q + 16'h0001;
                    if (conv_end)
                    begin
                        if (!chop_q)
                        begin
                            result_q <= gif.scaled_code;
                            o_data_ready <= 1'b1;
                            state_q <= AFE_DONE;
                        end
                        else
                        begin
                            pos_q <= i_filter_code;
                            o_filter_reset <= 1'b1;
                            state_q <= AFE_CONV_NEG;
                        end
                    end
                end
                AFE_CONV_NEG:
                begin
                    cnt_q <= conv_end ? 16'h0000 : cnt_q + 16'h0001;
                    // data ready only after both phases
                    if (conv_end)
                    begin
                        result_q <= gif.scaled_code;
                        o_data_ready <= 1'b1;
                        state_q <= AFE_DONE;
                    end
                end
                AFE_DONE:
                begin
                    if (mode_q == `AFE_MODE_CONT)
                    begin
                        o_filter_reset <= chop_q;
                        state_q <= AFE_CONV_POS;
                    end
                    else
                        state_q <= AFE_IDLE;
                end
                default: state_q <= AFE_IDLE;
            endcase
        end
    end

    // Analog-side controls, registered
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            o_mux_route <= `AFE_MUX_RESET;
            o_swap_inputs <= 1'b0;
            o_burnout_sel <= 2'h0;
            o_diode_bias_en <= 1'b0;
            o_analog_gain <= `AFE_GAIN_RESET;
        end
        else
        begin
            o_mux_route <= route;
            // swap only in the second phase
            o_swap_inputs <= (state_q == AFE_CONV_NEG);
            // sensor overrides burnout, stored bits untouched
            o_burnout_sel <= temp_sel ? 2'h0 : cs_sel_q;
            o_diode_bias_en <= temp_sel;
            // analog code follows gain up to 16x
            // codes above hold analog at 16x
            o_analog_gain <= (gain_q > 3'h5) ? 3'h5 : gain_q;
        end
    end

    // Read port, data one cycle after strobe
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            o_rdata <= 32'h00000000;
        else if (i_rd)
        begin
            case (i_addr)
                `AFE_ADDR_CFG0: o_rdata <= {30'h0, cs_sel_q};
                `AFE_ADDR_CFG2: o_rdata <= {28'h0, gain_q, chop_q};
                `AFE_ADDR_CFG3: o_rdata <= {30'h0, mode_q};
                `AFE_ADDR_MUX: o_rdata <= {24'h0, mux_q};
                `AFE_ADDR_CTRL: o_rdata <= {30'h0, scan_q, 1'b0};
                `AFE_ADDR_STAT: o_rdata <= {29'h0, state_q};
                `AFE_ADDR_RESULT: o_rdata <= {8'h0, result_q};
                default: o_rdata <= 32'h00000000;
            endcase
        end
        else
            o_rdata <= 32'h00000000;
    end
endmodule : afe_ctrl_top

// ### hw/afe_ctrl_regs.svh
// Register offsets, field positions, reset values and mode codes
// How it works
// - Mux code 0xDE routes positive diode to plus input, negative to minus.
// - Sensor selected directly or by sequencer disables burnout source, keeps stored bits.
// - Chop enable low gives plain conversions, no swapping, normal timing.
// - Chop enabled takes two conversions: normal polarity, then inputs swapped.
// - Chop result is normal conversion minus swapped conversion, halved.
// - Chop doubles conversion time; in one-shot that is the only timing change.
// - Chop with continuous mode resets filter between conversions, one result per two.
// - Gain codes 000 to 101 give analog 0.33x to 16x, digital 1x.
// - Gain codes 110 and 111 keep analog 16x, digital 2x and 4x.
// - Digital gain is a left shift of the conversion code, saturated to 24 bits, no rounding.
`ifndef AFE_CTRL_REGS_SVH
`define AFE_CTRL_REGS_SVH
`define AFE_ADDR_CFG0 4'h0
`define AFE_ADDR_CFG2 4'h1
`define AFE_ADDR_CFG3 4'h2
`define AFE_ADDR_MUX 4'h3
`define AFE_ADDR_CTRL 4'h4
`define AFE_ADDR_STAT 4'h5
`define AFE_ADDR_RESULT 4'h6
`define AFE_CFG0_CS_LSB 0
`define AFE_CFG2_CHOP_BIT 0
`define AFE_CFG2_GAIN_LSB 1
`define AFE_CFG3_MODE_LSB 0
`define AFE_CTRL_START_BIT 0
`define AFE_CTRL_SCAN_BIT 1
`define AFE_MUX_RESET 8'h01
`define AFE_GAIN_RESET 3'h1
`define AFE_TEMP_MUX_CODE 8'hDE
`define AFE_MODE_CONT 2'h3
`define AFE_MODE_ONESHOT 2'h2
`endif

// ### hw/afe_ctrl_pkg.sv
// Types shared by the front-end control modules
package afe_ctrl_pkg;
    typedef enum logic [2:0] {
        AFE_IDLE = 3'b000,
        AFE_CONV_POS = 3'b001,
        AFE_CONV_NEG = 3'b010,
        AFE_DONE = 3'b011
    } afe_state_e;
    typedef logic [23:0] afe_code_t;
endpackage : afe_ctrl_pkg

// ### hw/afe_gain_if.sv
// Gain request and scaled result between control and gain stage
`timescale 1ns/1ps
interface afe_gain_if;
    logic [2:0] gain_code;
    logic [23:0] raw_code;
    logic [23:0] scaled_code;
    modport ctrl (output gain_code, output raw_code, input scaled_code);
    modport stage (input gain_code, input raw_code, output scaled_code);
endinterface : afe_gain_if

// ### hw/afe_digital_gain.sv
// Digital gain stage: shift left with saturation
`timescale 1ns/1ps
module afe_digital_gain
    import afe_ctrl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    afe_gain_if.stage gif
);
    logic [1:0] shift_q;
    logic signed [26:0] wide;
    // digital gain select
    // Registered: a gain change only matters at a phase end, many clocks on
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
            shift_q <= 2'h0;
        else
        begin
            case (gif.gain_code)
                3'h6: shift_q <= 2'h1;
                3'h7: shift_q <= 2'h2;
                default: shift_q <= 2'h0;
            endcase
        end
    end
    always_comb
    begin
        wide = 27'(signed'(gif.raw_code)) <<< shift_q;
        if (wide > 27'sh07FFFFF)
            gif.scaled_code = 24'h7FFFFF;
        else if (wide < -27'sh0800000)
            gif.scaled_code = 24'h800000;
        else
            gif.scaled_code = wide[23:0];
    end
endmodule : afe_digital_gain

// ### verification/afe_ctrl_monitor.sv
// Port-level properties of the front-end control block
`timescale 1ns/1ps
module afe_ctrl_monitor
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [7:0] o_mux_route,
    input wire logic o_swap_inputs,
    input wire logic [1:0] o_burnout_sel,
    input wire logic o_diode_bias_en,
    input wire logic o_filter_reset,
    input wire logic [2:0] o_analog_gain,
    input wire logic o_data_ready
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // Stable route guards against the one-cycle register lag
    property p_bias_on;
        o_mux_route == 8'hDE && $stable(o_mux_route) |-> o_diode_bias_en;
    endproperty
    a_bias_on: assert property (p_bias_on)
        else $error("sensor route without diode bias");
    property p_burn_off;
        o_mux_route == 8'hDE && $stable(o_mux_route) |-> !o_burnout_sel;
    endproperty
    a_burn_off: assert property (p_burn_off)
        else $error("burnout source left on");
    property p_bias_off;
        o_mux_route != 8'hDE && $stable(o_mux_route) |-> !o_diode_bias_en;
    endproperty
    a_bias_off: assert property (p_bias_off)
        else $error("diode bias on other route");
    property p_gain_max;
        o_analog_gain <= 3'h5;
    endproperty
    a_gain_max: assert property (p_gain_max)
        else $error("analog gain above 16x");
    property p_swap_ready;
        $rose(o_swap_inputs) |-> !o_data_ready [*3];
    endproperty
    a_swap_ready: assert property (p_swap_ready)
        else $error("result before swapped phase");
    property p_ready_gap;
        o_data_ready |=> !o_data_ready [*4];
    endproperty
    a_ready_gap: assert property (p_ready_gap)
        else $error("results too close");
    property p_freset;
        o_filter_reset |=> !o_filter_reset;
    endproperty
    a_freset: assert property (p_freset)
        else $error("filter reset not a pulse");
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read");
    c_bias: cover property (o_diode_bias_en);
    c_swap: cover property ($rose(o_swap_inputs));
    c_freset: cover property (o_filter_reset);
endmodule : afe_ctrl_monitor
bind afe_ctrl_top afe_ctrl_monitor afe_ctrl_monitor_inst (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_mux_route(o_mux_route),
    .o_swap_inputs(o_swap_inputs),
    .o_burnout_sel(o_burnout_sel),
    .o_diode_bias_en(o_diode_bias_en),
    .o_filter_reset(o_filter_reset),
    .o_analog_gain(o_analog_gain),
    .o_data_ready(o_data_ready)
);

// ### verification/afe_ctrl_top_test.sv
// Self-checking bench for the front-end control block
`timescale 1ns/1ps
module afe_ctrl_top_test import afe_ctrl_pkg::*;;
    localparam int CC = 8;
    logic i_clock = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv;
    afe_code_t i_filter_code = 24'h0, ex, p;
    logic [7:0] i_scan_mux = 8'h00, o_mux_route;
    logic o_swap_inputs, o_diode_bias_en, o_filter_reset, o_data_ready;
    logic [1:0] o_burnout_sel;
    logic [2:0] o_analog_gain;
    logic [15:0] sd = 16'h0024;
    logic sw, fr;
    logic signed [24:0] df;
    int failures = 0, checks_done = 0, n;
    // Free-running clock
    always #10 i_clock = ~i_clock;
    afe_ctrl_top #(.CONV_CYCLES(CC)) afe_ctrl_top_inst (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_filter_code(i_filter_code),
        .i_scan_mux(i_scan_mux),
        .o_rdata(o_rdata),
        .o_mux_route(o_mux_route),
        .o_swap_inputs(o_swap_inputs),
        .o_burnout_sel(o_burnout_sel),
        .o_diode_bias_en(o_diode_bias_en),
        .o_filter_reset(o_filter_reset),
        .o_analog_gain(o_analog_gain),
        .o_data_ready(o_data_ready)
    );
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    // Expected result: digital gain 1, 2 or 4, clamped to 24 signed bits
    function automatic afe_code_t gain_exp(input int g, input afe_code_t v);
        int w;
        w = int'(signed'(v)) * (g == 7 ? 4 : (g == 6 ? 2 : 1));
        if (w > 32'sh007FFFFF)
            return 24'h7FFFFF;
        if (w < -32'sh00800000)
            return 24'h800000;
        return w[23:0];
    endfunction : gain_exp
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge i_clock);
        #1;
    endtask : settle
    // Bounded wait for a result; swapped phase sees the second code
    task automatic run(input afe_code_t ng);
        n = 0;
        sw = 1'b0;
        fr = 1'b0;
        do
        begin
            @(posedge i_clock);
            if (o_swap_inputs === 1'b1)
                i_filter_code <= ng;
            #1;
            n++;
            sw |= o_swap_inputs;
            fr |= o_filter_reset;
        end while (o_data_ready !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            failures++;
            stop_test();
        end
    endtask : run
    initial
    begin
        repeat (11) @(posedge i_clock);
        #1;
        chk(o_mux_route, 32'h01);
        chk(o_analog_gain, 32'h1);
        // Release on the twelfth edge, so the next edge sees it high
        @(posedge i_clock);
        i_reset_n <= 1'b1;
        wr(4'h0, 32'h3);
        wr(4'h3, 32'hDE);
        settle();
        chk(o_mux_route, 32'hDE);
        chk(o_burnout_sel, 32'h0);
        chk(o_diode_bias_en, 32'h1);
        rd(4'h0);
        chk(rv, 32'h3);
        sd = nx(sd);
        wr(4'h3, {24'h0, sd[7:1], 1'b1});
        settle();
        chk(o_burnout_sel, 32'h3);
        @(posedge i_clock);
        i_scan_mux <= 8'hDE;
        wr(4'h4, 32'h2);
        settle();
        chk(o_burnout_sel, 32'h0);
        wr(4'h4, 32'h0);
        $display("test route done");
        for (int g = 0; g < 8; g++)
        begin
            sd = nx(sd);
            p = {12'h0, sd[11:0]};
            // Hand-picked codes push the two digital gains past the clamp
            if (g == 6)
                p = 24'hA00000;
            if (g == 7)
                p = 24'h300000;
            wr(4'h1, 32'(g << 1));
            i_filter_code <= p;
            wr(4'h4, 32'h1);
            run(p);
            rd(4'h6);
            ex = gain_exp(g, p);
            chk(o_analog_gain, g > 5 ? 5 : g);
            chk(rv[23:0], ex);
            chk({31'h0, sw}, 32'h0);
            chk(32'(n < 2 * CC + 2), 32'h1);
        end
        $display("test gain done");
        wr(4'h1, 32'h3);
        for (int k = 0; k < 2; k++)
        begin
            sd = nx(sd);
            p = {{8{sd[15]}}, sd[15:1], 1'b0};
            ex = {{8{sd[7]}}, sd[7:0], sd[15:9], 1'b0};
            wr(4'h4, 32'h1);
            i_filter_code <= p;
            run(ex);
            rd(4'h6);
            df = $signed({p[23], p}) - $signed({ex[23], ex});
            chk(rv[23:0], df[24:1]);
            chk({31'h0, sw}, 32'h1);
            chk(32'(n >= 2 * CC), 32'h1);
        end
        $display("test chop done");
        wr(4'h2, 32'h3);
        wr(4'h4, 32'h1);
        run(ex);
        run(ex);
        chk(32'(n >= 2 * CC), 32'h1);
        chk({31'h0, fr}, 32'h1);
        wr(4'h9, 32'h5A);
        rd(4'h9);
        chk(rv, 32'h0);
        $display("test continuous done");
        stop_test();
    end
endmodule : afe_ctrl_top_test
